// ===== mbia_arbiter.sv
// Interrupt line drive and board arbitration for the acknowledge cycle.
//
// Contract
// - Sole board or chain without controller: request on main line only.
// - Vector arbitration without controller: drive main line and own vector line.
// - With a vector controller: main line released, own vector line only.
// - Chain: assert disable downstream until own request serviced.
// - Chain port has a disable input from above and output below.
// - Chain only: vector comparison defeated, mode straps unset.
// - Vector mode: watch all eight lines, answer when top line matches.
// - Each board drives exactly one distinct vector line, eight boards maximum.
// - Priority straps hold line index; priority number is its complement.
// - Address mode: answer only when address level matches own priority.
// - Mode strap selects exactly one comparison, each a fixed pattern.
// - Code buffer drives data in acknowledge only when mode condition holds.
// - Disabled arbiter setting supports chain-only operation.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module mbia_arbiter (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire mbia_pkg::mbia_straps_t       straps,
  input  wire logic                         req,
  input  wire mbia_pkg::mbia_ack_t          ack,
  input  wire logic [mbia_pkg::NUM_VI-1:0]  vi_in,
  input  wire logic                         chain_dis_in,
  input  wire mbia_pkg::mbia_bus_t          bus,
  output logic      [7:0]                   rdata,
  output logic                              main_int_out,
  output logic                              main_int_oe,
  output logic      [mbia_pkg::NUM_VI-1:0]  vi_out,
  output logic      [mbia_pkg::NUM_VI-1:0]  vi_oe,
  output logic                              chain_dis_out,
  output logic      [7:0]                   data_out,
  output logic                              data_oe,
  output logic                              irq
);
  import mbia_pkg::*;

  // Pin inputs except the acknowledge code are synchronised; straps are static jumpers caught once after reset.
  localparam int unsigned SW = 1 + LVL_W + NUM_VI + 1;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  assign sync_in = {ack.inta, ack.addr_level, vi_in, chain_dis_in};

  mbia_sync #(.W(SW)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (sync_in),
    .dout (sync_out)
  );

  logic             inta_s;
  logic [LVL_W-1:0] addr_lvl_s;
  logic [NUM_VI-1:0] vi_s;
  logic             chain_dis_s;
  assign {inta_s, addr_lvl_s, vi_s, chain_dis_s} = sync_out;

  // Straps are caught by a clocked process after reset release.
  mbia_straps_t straps_reg;
  logic         straps_valid_reg;
  logic [7:0]   cfg_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      straps_reg       <= '0;
      straps_valid_reg <= 1'b0;
    end else if (!straps_valid_reg) begin
      straps_reg       <= straps;
      straps_valid_reg <= 1'b1;
    end
  end

  // Decoded mode; an unset mode strap disables comparison.
  mbia_mode_t mode;
  always_comb begin
    if (straps_reg.mode_strap == MODE_STRAP_VI) begin
      mode = MBIA_MODE_VI;
    end else if (straps_reg.mode_strap == MODE_STRAP_ADDR) begin
      mode = MBIA_MODE_ADDR;
    end else begin
      mode = MBIA_MODE_CHAIN;
    end
  end

  // Software may disable the arbiter through bit 0 of the configuration register.
  logic             sw_dis;
  assign sw_dis = cfg_reg[0];

  logic [LVL_W-1:0] own_line;
  logic [LVL_W-1:0] own_prio;
  assign own_line = straps_reg.prio_strap;
  assign own_prio = line_to_prio(own_line);

  logic [LVL_W-1:0] enc_prio;
  logic             enc_any;
  mbia_prio_enc u_enc (
    .vi_active (vi_s),
    .prio      (enc_prio),
    .any       (enc_any)
  );

  // Request pending until a winning acknowledge services it.
  logic pending_reg;
  logic serviced;

  // Win condition for the active mode.
  logic vi_match;
  logic addr_match;
  logic win;
  assign vi_match   = enc_any && (enc_prio == own_prio);
  assign addr_match = addr_lvl_s == own_prio;
  always_comb begin
    case (mode)
      MBIA_MODE_VI:   win = vi_match;
      MBIA_MODE_ADDR: win = addr_match;
      default:        win = 1'b1;
    endcase
    win = win && !chain_dis_s && pending_reg && straps_valid_reg && !sw_dis;
  end

  // Acknowledge cycle state machine; the decision is frozen for the cycle.
  // A losing board waits in HOLD until the acknowledge ends.
  mbia_state_t state_reg;
  mbia_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MBIA_ST_IDLE:  if (inta_s) state_next = win ? MBIA_ST_DRIVE : MBIA_ST_HOLD;
      MBIA_ST_DRIVE: if (!inta_s) state_next = MBIA_ST_DONE;
      MBIA_ST_HOLD:  if (!inta_s) state_next = MBIA_ST_IDLE;
      MBIA_ST_DONE:  state_next = MBIA_ST_IDLE;
      default:       state_next = MBIA_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= MBIA_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Service is the fall of the acknowledge after a winning entry.
  assign serviced = (state_reg == MBIA_ST_DRIVE) && !inta_s;

  // A new request beats the service clear.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pending_reg <= 1'b0;
    end else if (req) begin
      pending_reg <= 1'b1;
    end else if (serviced) begin
      pending_reg <= 1'b0;
    end
  end

  // Code buffer: latched at the winning entry, released otherwise.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_out <= CODE_RESET;
      data_oe  <= 1'b0;
    end else if (state_reg == MBIA_ST_IDLE && inta_s && win) begin
      data_out <= ack.code;
      data_oe  <= 1'b1;
    end else if (state_next != MBIA_ST_DRIVE) begin
      data_oe  <= 1'b0;
    end
  end

  // Interrupt lines are open-collector: an enable high pulls the line active.
  logic act;
  logic vi_use;
  assign act    = pending_reg && straps_valid_reg && !sw_dis;
  assign vi_use = (mode == MBIA_MODE_VI) || straps_reg.vic_present;

  // Main line only when no vector controller and the main strap is fitted.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      main_int_out <= 1'b0;
      main_int_oe  <= 1'b0;
    end else begin
      main_int_out <= 1'b0;
      main_int_oe  <= act && straps_reg.main_line_drive_strap
                      && !straps_reg.vic_present;
    end
  end

  // Only the strapped vector line is ever enabled.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vi_out <= '0;
      vi_oe  <= '0;
    end else begin
      vi_out <= '0;
      for (int i = 0; i < NUM_VI; i++) begin
        vi_oe[i] <= act && vi_use && (own_line == LVL_W'(i));
      end
    end
  end

  // The disable passes downstream while upstream disables us or we are pending and not disabled by software.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chain_dis_out <= 1'b0;
    end else begin
      chain_dis_out <= chain_dis_s || act;
    end
  end

  // One write strobe decode, shared by every write target.
  function automatic logic wr_hit(input mbia_bus_t b, input logic [REG_AW-1:0] ofs);
    return b.wr && (b.addr == ofs);
  endfunction

  // Event status, enable and clear; a new event beats a clear.
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] stat_reg;
  logic [EVT_W-1:0] en_reg;
  logic [EVT_W-1:0] clr;
  logic             req_d_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_d_reg <= 1'b0;
    end else begin
      req_d_reg <= act;
    end
  end

  // Event sources, each a one-cycle or level condition.
  always_comb begin
    evt              = '0;
    evt[EVT_GRANT]   = state_reg == MBIA_ST_IDLE && inta_s && win;
    evt[EVT_LOSS]    = state_reg == MBIA_ST_IDLE && inta_s && !win && pending_reg;
    evt[EVT_CHAIN]   = chain_dis_s && pending_reg;
    evt[EVT_REQUEST] = act && !req_d_reg;
  end

  assign clr = wr_hit(bus, OFS_IRQ_CLR) ? bus.wdata[EVT_W-1:0] : '0;

  // An event in the same cycle as its clear leaves the bit set.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_reg <= EVT_RESET;
    end else begin
      stat_reg <= (stat_reg & ~clr) | evt;
    end
  end

  // The interrupt follows the next status value, so it lines up with stat_reg.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_reg & ~clr) | evt) & en_reg);
    end
  end

  // Configuration register: bit 0 lets software silence the card.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_hit(bus, OFS_CFG)) begin
      cfg_reg <= bus.wdata;
    end
  end

  // Interrupt enable register, same layout as the status register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_reg <= EVT_RESET;
    end else if (wr_hit(bus, OFS_IRQ_EN)) begin
      en_reg <= bus.wdata[EVT_W-1:0];
    end
  end

  // Register reads: data in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      if (bus.addr == OFS_CFG) begin
        rdata <= cfg_reg;
      end else if (bus.addr == OFS_STATUS) begin
        rdata <= {pending_reg, win, mode, own_prio, data_oe};
      end else if (bus.addr == OFS_IRQ_STAT) begin
        rdata <= 8'(stat_reg);
      end else if (bus.addr == OFS_IRQ_EN) begin
        rdata <= 8'(en_reg);
      end else begin
        rdata <= '0;
      end
    end else begin
      rdata <= '0;
    end
  end
endmodule // mbia_arbiter

// ===== mbia_asserts.sv
// Port-level assertions for the interrupt arbiter.
`timescale 1ns/1ps
module mbia_asserts (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire mbia_pkg::mbia_straps_t  straps,
  input wire mbia_pkg::mbia_ack_t     ack,
  input wire logic [7:0]              vi_in,
  input wire logic                    chain_dis_in,
  input wire mbia_pkg::mbia_bus_t     bus,
  input wire logic [7:0]              rdata,
  input wire logic                    main_int_oe,
  input wire logic [7:0]              vi_oe,
  input wire logic                    chain_dis_out,
  input wire logic                    data_oe
);
  import mbia_pkg::*;
  logic vi_win;
  logic vi_mode;
  // High when the lowest active vector line is this board's own line.
  assign vi_win = (vi_in & ((8'h2 << straps.prio_strap) - 8'h1)) == (8'h1 << straps.prio_strap);
  assign vi_mode = straps.mode_strap == MODE_STRAP_VI;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_MAIN_VIC: assert property (straps.vic_present |-> !main_int_oe)
    else $error("main line driven with controller present");
  AST_VI_ONEHOT: assert property ($onehot0(vi_oe))
    else $error("more than one vector line driven");
  AST_VI_SEL: assert property (vi_oe != 8'h00 |-> vi_oe == (8'h1 << straps.prio_strap))
    else $error("wrong vector line driven");
  AST_MAIN_ONLY: assert property (!vi_mode && !straps.vic_present |-> vi_oe == 8'h00)
    else $error("vector line driven outside vector mode");
  AST_VI_BOTH: assert property (vi_mode && !straps.vic_present && vi_oe != 8'h00 |-> main_int_oe)
    else $error("main line not driven beside vector line");
  AST_VI_LOSE: assert property ((vi_mode && !vi_win) [*6] |=> !$rose(data_oe))
    else $error("code driven without vector priority");
  AST_ADDR_LOSE: assert property ((straps.mode_strap == MODE_STRAP_ADDR &&
    ack.addr_level != ~straps.prio_strap) [*6] |=> !$rose(data_oe))
    else $error("code driven on address level mismatch");
  AST_CHAIN_HOLD: assert property (chain_dis_in [*6] |=> !$rose(data_oe))
    else $error("code driven while chain disabled");
  AST_ACK_END: assert property ((!ack.inta) [*6] |=> !data_oe)
    else $error("code driven outside acknowledge");
  AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read answer cycle");
  cover property ($rose(data_oe));
  cover property (straps.vic_present && vi_oe != 8'h00);
  cover property ($fell(chain_dis_out));
endmodule // mbia_asserts

// ===== mbia_host.sv
// Host processor and neighbouring boards as seen from the arbiter pins.
`timescale 1ns/1ps
module mbia_host (
  input  wire logic            clk,
  input  wire logic [7:0]      others,
  input  wire logic [7:0]      vi_oe,
  input  wire logic            data_oe,
  input  wire logic [7:0]      data_out,
  output mbia_pkg::mbia_ack_t  ack,
  output logic      [7:0]      vi_in
);
  import mbia_pkg::*;
  // Vector lines are wired-or: each other board pulls only its own line.
  assign vi_in = others | vi_oe;
  initial ack = '0;
  task automatic acknowledge(input logic [2:0] lvl, input logic [7:0] code,
                             output logic got, output logic [7:0] seen);
    got = 1'b0;
    seen = 8'h00;
    @(posedge clk);
    ack <= '{inta: 1'b1, addr_level: lvl, code: code};
    // Outputs are looked at mid-cycle, where they have settled.
    repeat (12) begin
      @(negedge clk);
      if (data_oe === 1'b1) begin
        got = 1'b1;
        seen = data_out;
      end
    end
    @(posedge clk);
    // Released lines must not keep their last value.
    ack <= '{inta: 1'b0, addr_level: ~lvl, code: ~code};
    repeat (8) @(posedge clk);
  endtask
endmodule // mbia_host

// ===== mbia_pkg.sv
// Package with constants, types and register map of the interrupt arbiter.
package mbia_pkg;
  localparam int unsigned REG_AW = 4;
  localparam int unsigned LVL_W  = 3;
  localparam int unsigned NUM_VI = 8;
  localparam int unsigned EVT_W  = 4;

  localparam logic [REG_AW-1:0] OFS_CFG      = 4'h0;
  localparam logic [REG_AW-1:0] OFS_STATUS   = 4'h4;
  localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [REG_AW-1:0] OFS_IRQ_CLR  = 4'hc;
  localparam logic [REG_AW-1:0] OFS_IRQ_EN   = 4'h2;

  // Arbitration mode strap patterns; any other pattern leaves the
  // arbiter disabled, which is daisy-chain-only operation.
  localparam logic [2:0] MODE_STRAP_NONE = 3'h0;
  localparam logic [2:0] MODE_STRAP_VI   = 3'h5;
  localparam logic [2:0] MODE_STRAP_ADDR = 3'h3;

  localparam logic [7:0] CODE_RESET  = 8'h00;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  localparam int unsigned EVT_GRANT   = 0;
  localparam int unsigned EVT_LOSS    = 1;
  localparam int unsigned EVT_CHAIN   = 2;
  localparam int unsigned EVT_REQUEST = 3;

  typedef enum logic [1:0] {
    MBIA_MODE_CHAIN = 2'h0,
    MBIA_MODE_VI    = 2'h1,
    MBIA_MODE_ADDR  = 2'h3
  } mbia_mode_t;

  typedef enum logic [1:0] {
    MBIA_ST_IDLE  = 2'h0,
    MBIA_ST_DRIVE = 2'h1,
    MBIA_ST_HOLD  = 2'h2,
    MBIA_ST_DONE  = 2'h3
  } mbia_state_t;

  typedef struct packed {
    logic [2:0] mode_strap;
    logic [2:0] prio_strap;
    logic       main_line_drive_strap;
    logic       vic_present;
  } mbia_straps_t;

  typedef struct packed {
    logic             inta;
    logic [LVL_W-1:0] addr_level;
    logic [7:0]       code;
  } mbia_ack_t;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } mbia_bus_t;

  // Priority number is the complement of the vector line index.
  function automatic logic [LVL_W-1:0] line_to_prio(input logic [LVL_W-1:0] line);
    return ~line;
  endfunction
endpackage

// ===== mbia_prio_enc.sv
// Vector-line priority encoder: line 0 wins and yields priority number 7.
`timescale 1ns/1ps
module mbia_prio_enc (
  input  wire logic [mbia_pkg::NUM_VI-1:0] vi_active,
  output logic      [mbia_pkg::LVL_W-1:0]  prio,
  output logic                             any
);
  import mbia_pkg::*;

  always_comb begin
    prio = '0;
    any  = 1'b0;
    for (int i = NUM_VI - 1; i >= 0; i--) begin
      if (vi_active[i]) begin
        prio = line_to_prio(LVL_W'(i));
        any  = 1'b1;
      end
    end
  end
endmodule // mbia_prio_enc

// ===== mbia_sync.sv
// Three-stage pin synchroniser; a change is taken once stages two and three agree.
`timescale 1ns/1ps
module mbia_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // mbia_sync

// ===== multi_board_interrupt_arbiter_bench.sv
// Randomised self-checking bench for the interrupt arbiter.
`timescale 1ns/1ps
module multi_board_interrupt_arbiter_bench;
  import mbia_pkg::*;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  mbia_straps_t straps = '0;
  logic         req = 1'b0;
  logic         chain_dis_in = 1'b0;
  mbia_bus_t    bus = '0;
  logic [7:0]   others = 8'h00;
  mbia_ack_t    ack;
  logic [7:0]   vi_in, rdata, vi_out, vi_oe, data_out;
  logic         main_int_out, main_int_oe, chain_dis_out, data_oe, irq;
  int           mismatches = 0;
  int           n_tests = 0;
  always #2.5 clk = ~clk;
  mbia_arbiter i_dut (.clk(clk), .nrst(nrst), .straps(straps), .req(req), .ack(ack),
    .vi_in(vi_in), .chain_dis_in(chain_dis_in), .bus(bus), .rdata(rdata),
    .main_int_out(main_int_out), .main_int_oe(main_int_oe), .vi_out(vi_out), .vi_oe(vi_oe),
    .chain_dis_out(chain_dis_out), .data_out(data_out), .data_oe(data_oe), .irq(irq));
  mbia_host i_host (.clk(clk), .others(others), .vi_oe(vi_oe), .data_oe(data_oe),
    .data_out(data_out), .ack(ack), .vi_in(vi_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  function automatic logic exp_win(logic [2:0] m, logic [2:0] p, logic [7:0] o,
                                   logic [2:0] l, logic c);
    if (m == MODE_STRAP_VI) return (o & ((8'h1 << p) - 8'h1)) == 8'h00;
    if (m == MODE_STRAP_ADDR) return l == ~p;
    return !c;
  endfunction
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [2:0] m, p, l;
    logic       v, c, w, got, ch;
    logic [7:0] o, d, seen, code;
    int         s;
    s = $urandom(25);
    for (int i = 0; i < 24; i++) begin
      m = (i % 4 == 0) ? MODE_STRAP_VI : (i % 4 == 1) ? MODE_STRAP_ADDR :
          (i % 4 == 2) ? MODE_STRAP_NONE : 3'($urandom);
      p = 3'($urandom);
      v = 1'($urandom);
      ch = m != MODE_STRAP_VI && m != MODE_STRAP_ADDR;
      c = ch && i % 4 == 3 && 1'($urandom);
      o = 8'($urandom) & ~(8'h1 << p);
      l = (i % 2 == 0) ? ~p : 3'($urandom);
      if (i % 2 == 0) o = o & ~((8'h1 << p) - 8'h1);
      @(posedge clk);
      nrst <= 1'b0;
      chain_dis_in <= 1'b0;
      straps <= '{mode_strap: m, prio_strap: p, main_line_drive_strap: !v, vic_present: v};
      others <= o;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      bus_wr(OFS_IRQ_EN, 8'h0e);
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (10) @(posedge clk);
      check(main_int_oe, !v);
      check(vi_oe, (m == MODE_STRAP_VI || v) ? 8'h1 << p : 8'h00);
      if (ch) check(chain_dis_out, 1'b1);
      check(irq, 1'b1);
      chain_dis_in <= c;
      repeat (6) @(posedge clk);
      w = exp_win(m, p, o, l, c);
      code = 8'($urandom);
      i_host.acknowledge(l, code, got, seen);
      check(got, w);
      if (w) check(seen, code);
      check(main_int_oe, !w && !v);
      if (ch) check(chain_dis_out, !w);
      bus_rd(OFS_IRQ_STAT, d);
      check(d & 8'hfb, {4'h0, 1'b1, 1'b0, !w, w});
      bus_rd(OFS_STATUS, d);
      check(d & 8'h8e, {!w, 3'h0, ~p, 1'b0});
      bus_wr(OFS_IRQ_CLR, 8'hff);
      repeat (3) @(posedge clk);
      // A lost chain request keeps raising its chain event, which beats the clear.
      check(irq, c);
      bus_rd(4'h1, d);
      check(d, 8'h00);
      bus_wr(OFS_CFG, 8'h01);
      bus_rd(OFS_CFG, d);
      check(d, 8'h01);
      check(main_int_oe, 1'b0);
      check(chain_dis_out, c);
    end
    report_and_stop();
  end
endmodule // multi_board_interrupt_arbiter_bench
bind mbia_arbiter mbia_asserts i_chk (.clk(clk), .nrst(nrst), .straps(straps), .ack(ack),
  .vi_in(vi_in), .chain_dis_in(chain_dis_in), .bus(bus), .rdata(rdata),
  .main_int_oe(main_int_oe), .vi_oe(vi_oe), .chain_dis_out(chain_dis_out), .data_oe(data_oe));
